// *** bcdg_defs.vh ***
// Constants for the bus clock divider and gating block
`ifndef BCDG_DEFS_VH
`define BCDG_DEFS_VH
// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define BCDG_IDX_AMBA 30'h5000000
`define BCDG_IDX_TRIM 30'h5000002
`define BCDG_IDX_RADIO 30'h5000008
`define BCDG_IDX_CTRL 30'h5000010
`define BCDG_ADDR_W 30
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BCDG_QSPI_EN 12
`define BCDG_QSPI_DIV_HI 11
`define BCDG_QSPI_DIV_LO 10
`define BCDG_OTP_EN 9
`define BCDG_RNG_EN 8
`define BCDG_ECC_EN 7
`define BCDG_AES_EN 6
`define BCDG_PCLK_DIV_HI 5
`define BCDG_PCLK_DIV_LO 4
`define BCDG_HCLK_DIV_HI 2
`define BCDG_HCLK_DIV_LO 0
`define BCDG_COARSE_HI 10
`define BCDG_COARSE_LO 8
`define BCDG_FINE_HI 7
`define BCDG_FINE_LO 0
`define BCDG_RADIO_EN 7
`define BCDG_LP_RESET 6
`define BCDG_RADIO_DIV_HI 5
`define BCDG_RADIO_DIV_LO 4
`define BCDG_RFCU_EN 3
`define BCDG_RF_CONTROL_CLK_DIVIDER_HI 1
`define BCDG_RF_CONTROL_CLK_DIVIDER_LO 0
`define BCDG_REF_DIV2 0
// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define BCDG_AMBA_MASK 16'h1ff7
`define BCDG_TRIM_MASK 16'h07ff
`define BCDG_RADIO_MASK 16'h00fb
`define BCDG_CTRL_MASK 16'h0001
`define BCDG_AMBA_RST 16'h0022
`define BCDG_TRIM_RST 16'h0000
`define BCDG_RADIO_RST 16'h0040
`define BCDG_CTRL_RST 16'h0000
// ----------------------------------------
// Divider encodings
// ----------------------------------------
`define BCDG_CODE_W 3
`define BCDG_CODE_DIV16 3'h4
`define BCDG_CNT_W 4
`define BCDG_TRIM_SETTLE_US 200
`endif

// *** bcdg_div_en.v ***
// Glitch-free divide-by-power-of-two clock enable generator
`timescale 1ns/1ps
module bcdg_div_en #(
  parameter CODE_W = 3
) (
  input wire CLK,
  input wire RST,
  input wire tick,
  input wire gate_on,
  input wire [CODE_W-1:0] code,
  output reg pulse_q
);
`include "bcdg_defs.vh"
  reg [`BCDG_CNT_W-1:0] cnt_q;
  reg [CODE_W-1:0] code_q;
  reg [`BCDG_CNT_W-1:0] last;

  // ----------------------------------------
  // Terminal count from the latched code
  // ----------------------------------------
  always @* begin
    if (code_q >= `BCDG_CODE_DIV16) begin
      last = 4'hf;
    end else begin
      last = (4'h1 << code_q[1:0]) - 4'h1;
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Code and gate are only taken at a period boundary, so a change never
  // yields a shortened period.
  always @(posedge CLK) begin
    if (RST) begin
      cnt_q <= 4'h0;
      code_q <= {CODE_W{1'b0}};
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= 1'b0;
      if (tick) begin
        if (cnt_q >= last) begin
          cnt_q <= 4'h0;
          code_q <= code;
          pulse_q <= gate_on;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

// *** bcdg_sync.v ***
// Two-flip-flop level synchroniser
`timescale 1ns/1ps
module bcdg_sync (
  input wire CLK,
  input wire RST,
  input wire d,
  output reg q
);
  reg meta_q;

  always @(posedge CLK) begin
    if (RST) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// *** bcdg_clock_ctrl.v ***
// Bus clock divider and gating control, register file and enable outputs
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module bcdg_clock_ctrl #(
  parameter CLK_MHZ = 40
) (
  input wire CLK,
  input wire RST,
  input wire [29:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire REF_TICK,
  input wire RADIO_CORE_SLEEP,
  input wire RADIO_REG_ACCESS,
  output wire HCLK_EN,
  output wire PCLK_EN,
  output wire QSPI_CLK_EN,
  output wire OTP_CLK_EN,
  output wire RANDOM_GEN_CLK_EN,
  output wire ECC_CLK_EN,
  output wire AES_CLK_EN,
  output wire RADIO_CORE_CLK_EN,
  output wire RF_CONTROL_CLK_EN,
  output wire RADIO_LOWPOWER_TIMER_RESET,
  output wire [2:0] CRYSTAL_TRIM_COARSE,
  output wire [7:0] CRYSTAL_TRIM_FINE,
  output reg HARD_FAULT
);
`include "bcdg_defs.vh"
  // Settle time in cycles, kept for reference by software drivers
  localparam integer TRIM_SETTLE_CYC = `BCDG_TRIM_SETTLE_US * CLK_MHZ;

  reg [15:0] amba_q;
  reg [15:0] trim_q;
  reg [15:0] radio_q;
  reg [15:0] ctrl_q;
  reg ref_half_q;
  wire sleep_s;
  wire ref_tick_s;
  reg ref_tick_d1_q;
  reg hclk_d1_q;
  wire ref_pulse;
  wire hclk_p;
  wire pclk_p;
  wire qspi_p;
  wire radio_p;
  wire rfcu_p;
  wire radio_on;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      amba_q <= `BCDG_AMBA_RST;
      trim_q <= `BCDG_TRIM_RST;
      radio_q <= `BCDG_RADIO_RST;
      ctrl_q <= `BCDG_CTRL_RST;
    end else if (WR) begin
      case (ADDR)
        `BCDG_IDX_AMBA: amba_q <= WDATA & `BCDG_AMBA_MASK;
        `BCDG_IDX_TRIM: trim_q <= WDATA & `BCDG_TRIM_MASK;
        `BCDG_IDX_RADIO: radio_q <= WDATA & `BCDG_RADIO_MASK;
        `BCDG_IDX_CTRL: ctrl_q <= WDATA & `BCDG_CTRL_MASK;
        default: begin
        end
      endcase
    end
  end

  // Unmapped addresses read as zero
  always @(posedge CLK) begin
    if (RST) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      case (ADDR)
        `BCDG_IDX_AMBA: RDATA <= amba_q;
        `BCDG_IDX_TRIM: RDATA <= trim_q;
        `BCDG_IDX_RADIO: RDATA <= radio_q;
        `BCDG_IDX_CTRL: RDATA <= ctrl_q;
        default: RDATA <= 16'h0000;
      endcase
    end else begin
      RDATA <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Source-side dividers
  // ----------------------------------------
  bcdg_div_en #(.CODE_W(3)) u_hclk (
    .CLK(CLK),
    .RST(RST),
    .tick(1'b1),
    .gate_on(1'b1),
    .code(amba_q[`BCDG_HCLK_DIV_HI:`BCDG_HCLK_DIV_LO]),
    .pulse_q(hclk_p)
  );

  // APB cascades from the AHB enable, not the source
  bcdg_div_en #(.CODE_W(2)) u_pclk (
    .CLK(CLK),
    .RST(RST),
    .tick(hclk_p),
    .gate_on(1'b1),
    .code(amba_q[`BCDG_PCLK_DIV_HI:`BCDG_PCLK_DIV_LO]),
    .pulse_q(pclk_p)
  );

  bcdg_div_en #(.CODE_W(2)) u_qspi (
    .CLK(CLK),
    .RST(RST),
    .tick(1'b1),
    .gate_on(amba_q[`BCDG_QSPI_EN]),
    .code(amba_q[`BCDG_QSPI_DIV_HI:`BCDG_QSPI_DIV_LO]),
    .pulse_q(qspi_p)
  );

  // The APB divider registers off the AHB pulse, so the AHB enable is
  // delayed one cycle to keep every APB pulse inside an AHB pulse.
  always @(posedge CLK) begin
    if (RST) begin
      hclk_d1_q <= 1'b0;
    end else begin
      hclk_d1_q <= hclk_p;
    end
  end

  assign HCLK_EN = hclk_d1_q;
  assign PCLK_EN = pclk_p;
  assign QSPI_CLK_EN = qspi_p;
  // Plain gates follow the AHB enable so a gate edge lands between pulses
  assign OTP_CLK_EN = hclk_d1_q & amba_q[`BCDG_OTP_EN];
  assign RANDOM_GEN_CLK_EN = hclk_d1_q & amba_q[`BCDG_RNG_EN];
  assign ECC_CLK_EN = hclk_d1_q & amba_q[`BCDG_ECC_EN];
  assign AES_CLK_EN = hclk_d1_q & amba_q[`BCDG_AES_EN];

  // ----------------------------------------
  // Radio reference and dividers
  // ----------------------------------------
  // The reference tick comes from another domain, so it is synchronised and
  // edge detected; it must be well below half the system clock rate.
  bcdg_sync u_ref (
    .CLK(CLK),
    .RST(RST),
    .d(REF_TICK),
    .q(ref_tick_s)
  );

  bcdg_sync u_sleep (
    .CLK(CLK),
    .RST(RST),
    .d(RADIO_CORE_SLEEP),
    .q(sleep_s)
  );

  always @(posedge CLK) begin
    if (RST) begin
      ref_tick_d1_q <= 1'b0;
      ref_half_q <= 1'b0;
    end else begin
      ref_tick_d1_q <= ref_tick_s;
      if (ref_tick_s & ~ref_tick_d1_q) begin
        ref_half_q <= ~ref_half_q;
      end
    end
  end

  // Optional halving keeps the reference at 16 MHz with a 32 MHz crystal
  assign ref_pulse = ref_tick_s & ~ref_tick_d1_q &
                     (~ctrl_q[`BCDG_REF_DIV2] | ref_half_q);

  assign radio_on = radio_q[`BCDG_RADIO_EN] & ~sleep_s;

  bcdg_div_en #(.CODE_W(2)) u_radio (
    .CLK(CLK),
    .RST(RST),
    .tick(ref_pulse),
    .gate_on(radio_on),
    .code(radio_q[`BCDG_RADIO_DIV_HI:`BCDG_RADIO_DIV_LO]),
    .pulse_q(radio_p)
  );

  bcdg_div_en #(.CODE_W(2)) u_rfcu (
    .CLK(CLK),
    .RST(RST),
    .tick(ref_pulse),
    .gate_on(radio_q[`BCDG_RFCU_EN]),
    .code(radio_q[`BCDG_RF_CONTROL_CLK_DIVIDER_HI:`BCDG_RF_CONTROL_CLK_DIVIDER_LO]),
    .pulse_q(rfcu_p)
  );

  assign RADIO_CORE_CLK_EN = radio_p;
  assign RF_CONTROL_CLK_EN = rfcu_p;
  assign RADIO_LOWPOWER_TIMER_RESET = radio_q[`BCDG_LP_RESET];
  assign CRYSTAL_TRIM_COARSE = trim_q[`BCDG_COARSE_HI:`BCDG_COARSE_LO];
  assign CRYSTAL_TRIM_FINE = trim_q[`BCDG_FINE_HI:`BCDG_FINE_LO];

  // ----------------------------------------
  // Hard fault on radio register access while its clock is off
  // ----------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      HARD_FAULT <= 1'b0;
    end else begin
      HARD_FAULT <= RADIO_REG_ACCESS & ~radio_on;
    end
  end
endmodule

// *** bcdg_props_properties.sv ***
// Port-level assertions for the clock divider and gating control
`timescale 1ns/1ps
module bcdg_props (
  input wire CLK,
  input wire RST,
  input wire [29:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [15:0] RDATA,
  input wire RADIO_REG_ACCESS,
  input wire HCLK_EN,
  input wire PCLK_EN,
  input wire OTP_CLK_EN,
  input wire RADIO_LOWPOWER_TIMER_RESET,
  input wire [2:0] CRYSTAL_TRIM_COARSE,
  input wire [7:0] CRYSTAL_TRIM_FINE,
  input wire HARD_FAULT
);
  // ----------------------------------------
  // Relations between requests and outputs
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_pclk_in_hclk: assert property (PCLK_EN |-> HCLK_EN)
    else $error("apb enable outside ahb enable");
  a_otp_in_hclk: assert property (OTP_CLK_EN |-> HCLK_EN)
    else $error("otp enable outside ahb enable");
  a_hclk_after_reset: assert property ($fell(RST) |-> ##[1:8] HCLK_EN)
    else $error("no ahb enable after reset");
  a_read_idle_zero: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside read cycle");
  a_fault_has_cause: assert property (HARD_FAULT |-> $past(RADIO_REG_ACCESS))
    else $error("fault without radio access");
  a_trim_write: assert property (WR && ADDR == 30'h5000002 |=>
    {CRYSTAL_TRIM_COARSE, CRYSTAL_TRIM_FINE} == 11'($past(WDATA)))
    else $error("trim outputs differ from write");
  a_trim_hold: assert property (!(WR && ADDR == 30'h5000002) |=>
    $stable(CRYSTAL_TRIM_FINE) && $stable(CRYSTAL_TRIM_COARSE))
    else $error("trim outputs moved without write");
  a_lp_write: assert property (WR && ADDR == 30'h5000008 |=>
    RADIO_LOWPOWER_TIMER_RESET == |($past(WDATA) & 16'h0040))
    else $error("timer reset differs from write");
  a_lp_hold: assert property (!(WR && ADDR == 30'h5000008) |=>
    $stable(RADIO_LOWPOWER_TIMER_RESET))
    else $error("timer reset moved without write");
endmodule
bind bcdg_clock_ctrl bcdg_props u_props (
  .CLK(CLK),
  .RST(RST),
  .ADDR(ADDR),
  .WDATA(WDATA),
  .WR(WR),
  .RD(RD),
  .RDATA(RDATA),
  .RADIO_REG_ACCESS(RADIO_REG_ACCESS),
  .HCLK_EN(HCLK_EN),
  .PCLK_EN(PCLK_EN),
  .OTP_CLK_EN(OTP_CLK_EN),
  .RADIO_LOWPOWER_TIMER_RESET(RADIO_LOWPOWER_TIMER_RESET),
  .CRYSTAL_TRIM_COARSE(CRYSTAL_TRIM_COARSE),
  .CRYSTAL_TRIM_FINE(CRYSTAL_TRIM_FINE),
  .HARD_FAULT(HARD_FAULT)
);

// *** test_bus_clock_divider_gating.sv ***
// Self-checking bench for the clock divider and gating control
`timescale 1ns/1ps
module test_bus_clock_divider_gating;
  logic CLK, RST, WR, RD, RADIO_CORE_SLEEP, RADIO_REG_ACCESS;
  logic REF_TICK = 1'b0;
  logic [29:0] ADDR;
  logic [15:0] WDATA;
  wire [15:0] RDATA;
  wire [2:0] CRYSTAL_TRIM_COARSE;
  wire [7:0] CRYSTAL_TRIM_FINE;
  wire HCLK_EN, PCLK_EN, QSPI_CLK_EN, OTP_CLK_EN, RANDOM_GEN_CLK_EN, ECC_CLK_EN, AES_CLK_EN;
  wire RADIO_CORE_CLK_EN, RF_CONTROL_CLK_EN, RADIO_LOWPOWER_TIMER_RESET, HARD_FAULT;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n, m, c;
  logic [2:0] ref_cnt = 3'h0;
  localparam logic [29:0] AMBA = 30'h5000000, TRIM = 30'h5000002, RADIO = 30'h5000008;
  // Oscillator settle time after a coarse trim step: 200 us of 25 ns cycles
  localparam int SETTLE = 8000;
  // Address, written value, value read back; coarse trim only steps 0 to 1 here
  logic [61:0] rows [7] = '{{AMBA, 16'hffff, 16'h1ff7}, {TRIM, 16'hf9ff, 16'h01ff},
    {RADIO, 16'hffff, 16'h00fb}, {30'h5000004, 16'hffff, 16'h0000},
    {30'h5000010, 16'hffff, 16'h0001}, {RADIO, 16'h0000, 16'h0000},
    {30'h5000010, 16'h0000, 16'h0000}};
  bcdg_clock_ctrl #(.CLK_MHZ(40)) dut (
    .CLK(CLK),
    .RST(RST),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WR(WR),
    .RD(RD),
    .RDATA(RDATA),
    .REF_TICK(REF_TICK),
    .RADIO_CORE_SLEEP(RADIO_CORE_SLEEP),
    .RADIO_REG_ACCESS(RADIO_REG_ACCESS),
    .HCLK_EN(HCLK_EN),
    .PCLK_EN(PCLK_EN),
    .QSPI_CLK_EN(QSPI_CLK_EN),
    .OTP_CLK_EN(OTP_CLK_EN),
    .RANDOM_GEN_CLK_EN(RANDOM_GEN_CLK_EN),
    .ECC_CLK_EN(ECC_CLK_EN),
    .AES_CLK_EN(AES_CLK_EN),
    .RADIO_CORE_CLK_EN(RADIO_CORE_CLK_EN),
    .RF_CONTROL_CLK_EN(RF_CONTROL_CLK_EN),
    .RADIO_LOWPOWER_TIMER_RESET(RADIO_LOWPOWER_TIMER_RESET),
    .CRYSTAL_TRIM_COARSE(CRYSTAL_TRIM_COARSE),
    .CRYSTAL_TRIM_FINE(CRYSTAL_TRIM_FINE),
    .HARD_FAULT(HARD_FAULT)
  );
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // Reference toggles every 3 cycles so the synchroniser sees every edge
  always @(posedge CLK) begin
    ref_cnt <= (ref_cnt == 3'h2) ? 3'h0 : ref_cnt + 3'h1;
    if (ref_cnt == 3'h2) REF_TICK <= ~REF_TICK;
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      stop_test;
    end
  end
  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  task chk(input string nm, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [29:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [29:0] a, input logic [15:0] e);
    @(posedge CLK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK) chk("read data", RDATA, e);
    @(negedge CLK) chk("read data after", RDATA, 16'h0000);
  endtask
  task rst_regs;
    rd(AMBA, 16'h0022);
    rd(TRIM, 16'h0000);
    rd(RADIO, 16'h0040);
  endtask
  // Several periods are skipped: a new code lands only at a period boundary
  task per(input int s, input logic [29:0] a, input logic [15:0] d, input int e);
    logic [4:0] v;
    wr(a, d);
    for (int k = 0; k < 4; k++) begin
      n = 0;
      @(negedge CLK);
      v = {RF_CONTROL_CLK_EN, RADIO_CORE_CLK_EN, QSPI_CLK_EN, PCLK_EN, HCLK_EN};
      while (v[s] !== 1'b1 && n < 400) begin
        n++;
        @(negedge CLK);
        v = {RF_CONTROL_CLK_EN, RADIO_CORE_CLK_EN, QSPI_CLK_EN, PCLK_EN, HCLK_EN};
      end
    end
    chk("enable period", 16'(n + 1), 16'(e));
  endtask
  task gates(input logic [15:0] d, input logic [4:0] e);
    wr(AMBA, d);
    repeat (20) @(negedge CLK);
    repeat (8) @(negedge CLK) chk("gated enables",
      16'({QSPI_CLK_EN, OTP_CLK_EN, RANDOM_GEN_CLK_EN, ECC_CLK_EN, AES_CLK_EN}), 16'(e));
  endtask
  task fault(input logic e, f);
    repeat (20) @(posedge CLK);
    n = 0;
    m = 0;
    repeat (24) @(negedge CLK) begin
      n += RADIO_CORE_CLK_EN;
      m += RF_CONTROL_CLK_EN;
    end
    @(posedge CLK) RADIO_REG_ACCESS <= 1'b1;
    @(posedge CLK) RADIO_REG_ACCESS <= 1'b0;
    @(negedge CLK) chk("hard fault", 16'(HARD_FAULT), 16'(e));
    chk("radio clock running", 16'(n > 0), 16'(!e));
    chk("rf clock running", 16'(m > 0), 16'(f));
  endtask
  task stop_test;
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {WR, RD, RADIO_CORE_SLEEP, RADIO_REG_ACCESS} = 4'h0;
    ADDR = AMBA;
    WDATA = 16'h0000;
    RST = 1'b1;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    rst_regs;
    chk("timer reset", 16'(RADIO_LOWPOWER_TIMER_RESET), 16'h0001);
    foreach (rows[i]) begin
      wr(rows[i][61:32], rows[i][31:16]);
      rd(rows[i][61:32], rows[i][15:0]);
    end
    chk("timer reset", 16'(RADIO_LOWPOWER_TIMER_RESET), 16'h0000);
    for (c = 0; c < 8; c++) per(0, AMBA, 16'(c), c > 3 ? 16 : 1 << c);
    for (c = 0; c < 4; c++) per(1, AMBA, 16'(c * 16 + 1), 2 << c);
    for (c = 0; c < 4; c++) per(2, AMBA, 16'(c * 1024 + 4096), 1 << c);
    for (c = 0; c < 4; c++) per(3, RADIO, 16'(c * 16 + 128), 6 << c);
    for (c = 0; c < 4; c++) per(4, RADIO, 16'(c + 8), 6 << c);
    wr(30'h5000010, 16'h0001);
    per(3, RADIO, 16'h0080, 12);
    wr(30'h5000010, 16'h0000);
    for (c = 0; c < 5; c++) gates(c == 4 ? 16'h1000 : 16'h0040 << c, 5'h01 << c);
    gates(16'h0000, 5'h00);
    wr(RADIO, 16'h0000);
    fault(1'b1, 1'b0);
    wr(RADIO, 16'h0089);
    fault(1'b0, 1'b1);
    @(posedge CLK) RADIO_CORE_SLEEP <= 1'b1;
    fault(1'b1, 1'b1);
    @(posedge CLK) RADIO_CORE_SLEEP <= 1'b0;
    repeat (SETTLE) @(posedge CLK);
    wr(TRIM, 16'h02a5);
    @(negedge CLK) chk("trim", 16'({CRYSTAL_TRIM_COARSE, CRYSTAL_TRIM_FINE}), 16'h02a5);
    @(posedge CLK) RST <= 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    rst_regs;
    stop_test;
  end
endmodule
